// [src/disk_status_pkg.sv]
// shared types and constants for the disk status and format-stream block
// assumes a single 250 MHz clock domain and a controller core on that clock
package disk_status_pkg;

  // ********************************
  // status bit positions
  // ********************************
  localparam int ST_NRDY = 7;
  localparam int ST_WPROT = 6;
  localparam int ST_HLD_RTYPE = 5;
  localparam int ST_SEEK_RNF = 4;
  localparam int ST_CRC = 3;
  localparam int ST_TRK0_LOST = 2;
  localparam int ST_INDEX_DRQ = 1;
  localparam int ST_BUSY = 0;
  // not-ready reads as set while reset is held
  localparam logic [7:0] STATUS_RST = 8'h80;

  // ********************************
  // format stream codes
  // ********************************
  localparam logic [7:0] CRC_GEN_CODE = 8'hF7;
  localparam logic [7:0] ZERO_FILL = 8'h00;
  localparam logic [1:0] CRC_BYTES = 2'h2;
  localparam logic [1:0] CRC_NONE = 2'h0;

  // ********************************
  // buffer shape
  // ********************************
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 32;

  // class of the most recent accepted command
  typedef enum logic [2:0] {
    CLS_POS, CLS_RD_ADDR, CLS_RD_SEC, CLS_RD_TRK, CLS_WR_SEC, CLS_WR_TRK
  } cls_e;

  // one-cycle result flags from the controller core
  typedef struct packed {
    logic seek_err;
    logic crc_err;
    logic record_not_found;
    logic deleted_mark;
    logic wp_hit;
    logic done;
  } evt_s;

  // one byte slot towards the write serializer
  typedef struct packed {
    logic [7:0] data;
    logic is_crc;
  } wbyte_s;

endpackage

// [src/disk_status.sv]
// status word and format byte stream of the floppy formatter/controller
// assumes drive pins are asynchronous and the core, host strobes share CLK
`timescale 1ns/10ps

module fmt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic clr,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = cnt_q != FULL_CNT;
  assign out_valid = cnt_q != '0;
  assign out_data = mem[rp_q];

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp_q] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (srst || clr)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      if (pop)
        rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module disk_status (
  // clock and reset (reset doubles as the master reset line)
  input wire logic CLK,
  input wire logic SRST,
  // drive pins, asynchronous
  input wire logic DRIVE_READY,
  input wire logic WRITE_PROTECT_INPUT_N,
  input wire logic HEAD_LOAD_TIMING_INPUT,
  input wire logic TRACK_ZERO_INPUT_N,
  input wire logic INDEX_PULSE_INPUT_N,
  // controller core
  input wire logic CMD_VALID,
  input wire disk_status_pkg::cls_e CMD_CLASS,
  input wire logic FORCE_INT,
  input wire logic HEAD_LOAD_REQ,
  input wire disk_status_pkg::evt_s EVT,
  input wire logic BYTE_TICK,
  input wire logic RD_BYTE_VALID,
  input wire logic [7:0] RD_BYTE,
  // host data register access
  input wire logic HOST_RD_DATA,
  input wire logic HOST_WR_DATA,
  input wire logic [7:0] HOST_DATA,
  // status and data towards host
  output logic [7:0] STATUS_Q,
  output logic [7:0] DATA_Q,
  output logic DATA_REQUEST,
  output logic HEAD_LOAD_OUTPUT,
  output logic CMD_REJECT,
  // byte slots towards the write serializer
  output logic WR_STB,
  output disk_status_pkg::wbyte_s WR_OUT
);
  import disk_status_pkg::*;

  // ********************************
  // pin synchronisers
  // ********************************
  logic [4:0] pin_m_q, pin_s_q;
  always_ff @(posedge CLK)
  begin
    pin_m_q <= {DRIVE_READY, WRITE_PROTECT_INPUT_N, HEAD_LOAD_TIMING_INPUT,
                TRACK_ZERO_INPUT_N, INDEX_PULSE_INPUT_N};
    pin_s_q <= pin_m_q;
  end
  wire ready_s = pin_s_q[4];
  wire wprot_n_s = pin_s_q[3];
  wire hlt_s = pin_s_q[2];
  wire trk0_n_s = pin_s_q[1];
  wire index_n_s = pin_s_q[0];

  // ********************************
  // command acceptance
  // ********************************
  cls_e cls_q;
  logic busy_q, seek_q, crc_q, rnf_q, rtype_q, wp_q, lost_q, drq_q;
  logic [1:0] crc_left_q;
  wire is_rw = CMD_CLASS != CLS_POS;
  wire cmd_ok = CMD_VALID && !FORCE_INT && (!is_rw || ready_s);
  wire cmd_bad = CMD_VALID && !FORCE_INT && is_rw && !ready_s;
  wire wr_mode = busy_q && (cls_q == CLS_WR_SEC || cls_q == CLS_WR_TRK);
  wire rd_mode = busy_q && (cls_q == CLS_RD_ADDR || cls_q == CLS_RD_SEC
                 || cls_q == CLS_RD_TRK);

  // ********************************
  // format byte path
  // ********************************
  logic f_ready, f_valid;
  logic [7:0] f_data;
  wire want_byte = BYTE_TICK && wr_mode && crc_left_q == CRC_NONE;
  wire pop_crc = want_byte && f_valid && f_data == CRC_GEN_CODE;
  // an empty buffer at byte time still yields a zero byte; lost data is flagged
  wire write_starved = want_byte && !f_valid;
  wire lost_set = (BYTE_TICK && rd_mode && drq_q) || write_starved;

  fmt_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CLK),
    .srst(SRST),
    .clr(cmd_ok),
    .in_valid(HOST_WR_DATA && wr_mode),
    .in_ready(f_ready),
    .in_data(HOST_DATA),
    .out_valid(f_valid),
    .out_ready(want_byte),
    .out_data(f_data)
  );

  // no index mark or gap length is checked: bytes pass as given except F7, which becomes two CRC slots
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      WR_STB <= 1'b0;
      WR_OUT <= '0;
      crc_left_q <= CRC_NONE;
    end
    else
    begin
      WR_STB <= BYTE_TICK && wr_mode;
      if (BYTE_TICK && wr_mode && crc_left_q != CRC_NONE)
      begin
        WR_OUT <= '{data: ZERO_FILL, is_crc: 1'b1};
        crc_left_q <= crc_left_q - 1'b1;
      end
      else if (pop_crc)
      begin
        WR_OUT <= '{data: ZERO_FILL, is_crc: 1'b1};
        crc_left_q <= CRC_BYTES - 1'b1;
      end
      else if (want_byte)
        WR_OUT <= '{data: f_valid ? f_data : ZERO_FILL, is_crc: 1'b0};
      if (!wr_mode)
        crc_left_q <= CRC_NONE;
    end
  end

  // ********************************
  // status state
  // ********************************
  // hardware sets win over the clear of a new command in the same cycle
  function automatic logic sticky(input logic cur, input logic clr, input logic set);
    sticky = (cur && !clr) || set;
  endfunction

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      cls_q <= CLS_POS;
      busy_q <= 1'b0;
      {seek_q, crc_q, rnf_q, rtype_q, wp_q, lost_q} <= '0;
      CMD_REJECT <= 1'b0;
      HEAD_LOAD_OUTPUT <= 1'b0;
    end
    else
    begin
      CMD_REJECT <= cmd_bad;
      HEAD_LOAD_OUTPUT <= HEAD_LOAD_REQ;
      if (cmd_ok)
        cls_q <= CMD_CLASS;
      else if (FORCE_INT && !busy_q)
        cls_q <= CLS_POS;
      if (cmd_ok)
        busy_q <= 1'b1;
      else if (FORCE_INT || EVT.done)
        busy_q <= 1'b0;
      seek_q <= sticky(seek_q, cmd_ok, EVT.seek_err);
      crc_q <= sticky(crc_q, cmd_ok, EVT.crc_err);
      rnf_q <= sticky(rnf_q, cmd_ok, EVT.record_not_found);
      rtype_q <= sticky(rtype_q, cmd_ok, EVT.deleted_mark);
      wp_q <= sticky(wp_q, cmd_ok, EVT.wp_hit);
      lost_q <= sticky(lost_q, cmd_ok, lost_set);
    end
  end

  // data request: a read byte waiting, or room in the buffer for a write
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      drq_q <= 1'b0;
      DATA_Q <= '0;
    end
    else
    begin
      if (RD_BYTE_VALID)
        DATA_Q <= RD_BYTE;
      if (wr_mode)
        drq_q <= f_ready && !HOST_WR_DATA;
      else
        drq_q <= sticky(drq_q, HOST_RD_DATA || cmd_ok, RD_BYTE_VALID);
    end
  end
  assign DATA_REQUEST = drq_q;

  // ********************************
  // status read multiplexer
  // ********************************
  wire rd_sec = cls_q == CLS_RD_SEC;
  wire has_rnf = rd_sec || cls_q == CLS_RD_ADDR || cls_q == CLS_WR_SEC;
  wire is_wr = cls_q == CLS_WR_SEC || cls_q == CLS_WR_TRK;
  wire [7:0] pos_view = {!ready_s, !wprot_n_s, HEAD_LOAD_OUTPUT && hlt_s, seek_q,
                         crc_q, !trk0_n_s, !index_n_s, busy_q};
  wire [7:0] rw_view = {!ready_s, wp_q && is_wr, rtype_q && rd_sec, rnf_q && has_rnf,
                        crc_q && has_rnf, lost_q, drq_q, busy_q};
  wire [7:0] status_d = (cls_q == CLS_POS) ? pos_view : rw_view;

  always_ff @(posedge CLK)
  begin
    if (SRST)
      STATUS_Q <= STATUS_RST;
    else
      STATUS_Q <= status_d;
  end

  // ********************************
  // assertions
  // ********************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  AST_BUSY_SHOWN: assert property (cmd_ok |=> ##1 STATUS_Q[ST_BUSY])
    else $error("busy not shown after accepted command");
  AST_NOT_READY_REFUSED: assert property (cmd_bad |=> CMD_REJECT && !busy_q)
    else $error("command accepted while drive not ready");
  // the word loaded while reset is held still reads not-ready one edge later
  AST_NRDY_BIT: assert property (
    STATUS_Q[ST_NRDY] == (!$past(ready_s) || $past(SRST)))
    else $error("not-ready bit disagrees with ready pin");
  AST_FORCE_IDLE: assert property (FORCE_INT && !busy_q && !CMD_VALID
    |=> cls_q == CLS_POS ##1 !STATUS_Q[ST_BUSY])
    else $error("idle forced interrupt did not select positioning view");
  AST_FORCE_KEEP: assert property (FORCE_INT && busy_q && EVT == '0 && !cmd_ok
    |=> !busy_q && $stable(rnf_q) && $stable(crc_q) && $stable(cls_q))
    else $error("forced interrupt disturbed status bits");
  AST_DRQ_CLEAR: assert property (HOST_RD_DATA && !RD_BYTE_VALID && !wr_mode
    |=> !DATA_REQUEST)
    else $error("data read did not clear data request");
  AST_LOST: assert property (BYTE_TICK && rd_mode && drq_q |=> lost_q)
    else $error("unserviced request did not set lost data");
  // the pair is split in two: the gap between byte times has no bound
  AST_CRC_PAIR: assert property (pop_crc
    |=> WR_STB && WR_OUT.is_crc && crc_left_q != CRC_NONE)
    else $error("F7 did not give a first CRC slot");
  AST_CRC_SECOND: assert property (BYTE_TICK && wr_mode && crc_left_q != CRC_NONE
    |=> WR_STB && WR_OUT.is_crc && crc_left_q == CRC_NONE)
    else $error("second CRC slot missing after F7");
  AST_TRK0_VIEW: assert property (cls_q == CLS_POS
    |=> STATUS_Q[ST_TRK0_LOST] == !$past(trk0_n_s))
    else $error("track zero bit wrong in positioning view");
  AST_WRITE_NO_RTYPE: assert property (is_wr |=> !STATUS_Q[ST_HLD_RTYPE])
    else $error("record type shown during write");

  COV_READ_LOST: cover property (rd_mode && BYTE_TICK && drq_q ##1 lost_q);
  COV_CRC_EMIT: cover property (pop_crc ##1 WR_OUT.is_crc);
  COV_FORCE_BUSY: cover property (busy_q && FORCE_INT ##1 !busy_q);
  COV_FIFO_FULL: cover property (wr_mode && !f_ready);
endmodule

// [testbench/drive_model.sv]
// behavioural floppy drive seen from the status block's pins
// assumes the bench sets the drive's condition through plain knobs
`timescale 1ns/10ps

module drive_model (
  // condition knobs from the bench
  input wire logic ready,
  input wire logic protect,
  input wire logic at_track0,
  input wire logic index_hole,
  input wire logic engaged,
  // head load request from the controller
  input wire logic head_load,
  // drive pins
  output logic drive_ready,
  output logic write_protect_n,
  output logic head_load_timing,
  output logic track_zero_n,
  output logic index_n
);
  // ********************************
  // pin levels, sensors are active low
  // ********************************
  assign drive_ready = ready;
  assign write_protect_n = ~protect;
  // head only engages while the controller actually loads it
  assign head_load_timing = head_load & engaged;
  assign track_zero_n = ~at_track0;
  assign index_n = ~index_hole;
endmodule

// [testbench/disk_status_bench.sv]
// self-checking bench for the status word and format stream block
// assumes a drive model on the pins and the bench acting as core and host
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s: expected %h seen %h", nm, e, g); end end

module disk_status_bench;
  import disk_status_pkg::*;
  logic clk = 0, srst = 1, rdy = 1, prot = 0, t0 = 0, idx = 0, eng = 0;
  logic hlreq = 0, cmd_valid = 0, fint = 0, tick_s = 0, rd_v = 0, h_rd = 0, h_wr = 0;
  logic [7:0] rd_byte = 8'h00, h_data = 8'h00, st, dq;
  logic data_request, hlo, rej, wr_stb, p_rdy, p_wp_n, p_hlt, p_t0_n, p_idx_n;
  cls_e cls = CLS_POS;
  evt_s evt = '0;
  wbyte_s wr_out;
  int err_count = 0, n_compared = 0;

  always #2 clk = ~clk;

  drive_model u_drive_model (.ready(rdy), .protect(prot), .at_track0(t0), .index_hole(idx),
    .engaged(eng), .head_load(hlo), .drive_ready(p_rdy), .write_protect_n(p_wp_n),
    .head_load_timing(p_hlt), .track_zero_n(p_t0_n), .index_n(p_idx_n));

  disk_status u_disk_status (.CLK(clk), .SRST(srst), .DRIVE_READY(p_rdy),
    .WRITE_PROTECT_INPUT_N(p_wp_n), .HEAD_LOAD_TIMING_INPUT(p_hlt),
    .TRACK_ZERO_INPUT_N(p_t0_n), .INDEX_PULSE_INPUT_N(p_idx_n), .CMD_VALID(cmd_valid),
    .CMD_CLASS(cls), .FORCE_INT(fint), .HEAD_LOAD_REQ(hlreq), .EVT(evt), .BYTE_TICK(tick_s),
    .RD_BYTE_VALID(rd_v), .RD_BYTE(rd_byte), .HOST_RD_DATA(h_rd), .HOST_WR_DATA(h_wr),
    .HOST_DATA(h_data), .STATUS_Q(st), .DATA_Q(dq), .DATA_REQUEST(data_request),
    .HEAD_LOAD_OUTPUT(hlo), .CMD_REJECT(rej), .WR_STB(wr_stb), .WR_OUT(wr_out));

  // ********************************
  // shared drivers
  // ********************************
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task cmd(input cls_e c);
    cls = c; cmd_valid = 1; cyc(1); cmd_valid = 0; cyc(3);
  endtask
  task ev(input evt_s e);
    evt = e; cyc(1); evt = '0; cyc(3);
  endtask
  task force_int;
    fint = 1; cyc(1); fint = 0; cyc(3);
  endtask
  task tick;
    tick_s = 1; cyc(1); tick_s = 0;
  endtask
  task hwr(input logic [7:0] d);
    h_data = d; h_wr = 1; cyc(1); h_wr = 0; cyc(1);
  endtask
  // a slot stands one cycle, so look at every falling edge for a few cycles
  task stb(input logic [7:0] d, input logic c);
    for (int i = 0; i < 5 && wr_stb !== 1'b1; i++) cyc(1);
    `CHK("wr_stb", 1'b1, wr_stb)
    `CHK("wr_out", {d, c}, wr_out)
    cyc(1);
  endtask
  // host bytes through the buffer, one per byte time, each in its own slot
  task send_byte(input logic [7:0] d, input int n);
    repeat (n)
    begin
      hwr(d);
      tick;
      stb(d, 1'b0);
    end
  endtask
  task send_crc;
    hwr(CRC_GEN_CODE);
    tick;
    stb(ZERO_FILL, 1'b1);
    tick;
    stb(ZERO_FILL, 1'b1);
  endtask

  // ********************************
  // scenarios
  // ********************************
  task t_position;
    prot = 1; t0 = 1; eng = 1; hlreq = 1;
    cmd(CLS_POS);
    `CHK("pos status", 8'h65, st)
    `CHK("head load", 1'b1, hlo)
    ev(6'h30);
    `CHK("pos errors", 8'h7D, st)
    ev(6'h01);
    `CHK("pos done", 8'h7C, st)
    cmd(CLS_POS);
    `CHK("pos cleared", 8'h65, st)
    ev(6'h20);
    force_int;
    // busy drops, the seek flag stays
    `CHK("fint busy", 8'h74, st)
    idx = 1; cyc(4);
    `CHK("index bit", 1'b1, st[ST_INDEX_DRQ])
    idx = 0; cyc(3);
  endtask

  task t_not_ready;
    rdy = 0; cyc(4);
    `CHK("not ready", 1'b1, st[ST_NRDY])
    cls = CLS_RD_SEC; cmd_valid = 1; cyc(1); cmd_valid = 0;
    `CHK("reject", 1'b1, rej)
    cyc(3);
    `CHK("no busy", 1'b0, st[ST_BUSY])
    rdy = 1; cyc(4);
  endtask

  task t_read;
    hlreq = 0;
    cmd(CLS_RD_SEC);
    `CHK("rd status", 8'h01, st)
    rd_byte = 8'hA5; rd_v = 1; cyc(1); rd_v = 0; cyc(2);
    `CHK("rd data", 8'hA5, dq)
    `CHK("rd drq bit", 1'b1, st[ST_INDEX_DRQ])
    tick; cyc(2);
    `CHK("rd lost", 1'b1, st[ST_TRK0_LOST])
    h_rd = 1; cyc(1); h_rd = 0; cyc(2);
    `CHK("rd drq clr", 1'b0, data_request)
    ev(6'h1C);
    `CHK("rd errors", 8'h3D, st)
    ev(6'h01);
    `CHK("rd done", 8'h3C, st)
    t0 = 0; force_int;
    // idle forced interrupt falls back to the positioning view
    `CHK("fint idle", 8'h40, st & 8'hE7)
  endtask

  task t_write;
    cmd(CLS_WR_TRK);
    `CHK("wr status", 8'h03, st)
    hwr(8'hF7); hwr(8'h4E);
    tick; stb(8'h00, 1'b1);
    tick; stb(8'h00, 1'b1);
    tick; stb(8'h4E, 1'b0);
    tick; stb(8'h00, 1'b0);
    ev(6'h02);
    `CHK("wr view", 8'h44, st & 8'h7C)
    for (int i = 0; i < FIFO_DEPTH; i++) hwr(8'(i));
    cyc(1);
    `CHK("full drq", 1'b0, data_request)
    hwr(8'hEE);
    for (int i = 0; i < FIFO_DEPTH; i++)
    begin
      tick;
      stb(8'(i), 1'b0);
    end
    cyc(2);
    `CHK("empty drq", 1'b1, data_request)
    ev(6'h01);
    `CHK("wr idle", 1'b0, st[ST_BUSY])
  endtask

  // the other read and write classes, with record-not-found and CRC raised
  task t_classes;
    cmd(CLS_WR_SEC);
    ev(6'h18);
    `CHK("wr sec view", 8'h1B, st)
    ev(6'h01);
    cmd(CLS_RD_TRK);
    ev(6'h18);
    `CHK("rd trk view", 8'h01, st)
    ev(6'h01);
    cmd(CLS_RD_ADDR);
    ev(6'h18);
    `CHK("rd addr view", 8'h19, st)
    ev(6'h01);
  endtask

  // one single-density 128-byte sector, then a double-density ID field and gap
  task t_format;
    cmd(CLS_WR_TRK);
    send_byte(8'hFF, 40);
    send_byte(8'h00, 6);
    send_byte(8'hFC, 1);
    send_byte(8'hFE, 1);
    send_byte(8'h00, 2);
    send_byte(8'h01, 1);
    send_byte(8'h00, 1);
    send_crc;
    send_byte(8'hFF, 11);
    send_byte(8'h00, 6);
    send_byte(8'hFB, 1);
    send_byte(8'hE5, 128);
    send_crc;
    send_byte(8'hFF, 27);
    send_byte(8'h00, 6);
    send_byte(8'h00, 12);
    send_byte(8'hF5, 3);
    send_byte(8'hFE, 1);
    send_byte(8'h00, 2);
    send_byte(8'h01, 2);
    send_crc;
    send_byte(8'h4E, 22);
    send_byte(8'h00, 12);
    send_byte(8'hF5, 3);
    send_byte(8'hFB, 1);
    cyc(2);
    `CHK("fmt no lost", 1'b0, st[ST_TRK0_LOST])
    ev(6'h01);
  endtask

  task end_sim;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    cyc(1);
    `CHK("reset status", STATUS_RST, st)
    cyc(15);
    srst = 0;
    cyc(4);
    t_position;
    t_not_ready;
    t_read;
    t_classes;
    t_write;
    t_format;
    end_sim;
  end

  // the scenarios need about fifteen hundred cycles
  initial
  begin
    #20000;
    err_count++;
    end_sim;
  end
endmodule
